// ---- pfh_params.svh ----
// ============================================================
// Fault handling constants: widths, field positions, resets
// ============================================================
// Included by the package and by the design modules.
// Assumes nothing beyond a SystemVerilog compiler.
`ifndef PFH_PARAMS_SVH
`define PFH_PARAMS_SVH

// Field widths of the four status groups
`define PFH_HARD_W        2
`define PFH_MM_W          5
`define PFH_BUS_W         6
`define PFH_USAGE_W       6

// Address and priority widths
`define PFH_ADDR_W        32
`define PFH_PRIO_W        8

// Bit positions inside the hard fault status group
`define PFH_HARD_VEC_BIT  0
`define PFH_HARD_ESC_BIT  1

// Reset values
`define PFH_FLAG_RST      1'h0
`define PFH_ADDR_RST      32'h0000_0000
`define PFH_PRIO_RST      8'h00

`endif

// ---- pfh_pkg.sv ----
// ============================================================
// Fault handling types
// ============================================================
// Status groups as packed structs, exception class enum.
// Assumes pfh_params.svh is on the include path.
`include "pfh_params.svh"

package pfh_pkg;

  // Class of exception handed to the entry logic
  typedef enum logic [1:0] {
    PFH_CLASS_HARD,
    PFH_CLASS_MM,
    PFH_CLASS_BUS,
    PFH_CLASS_USAGE
  } pfh_class_t;

  // Hard fault status group
  typedef struct packed {
    logic escalated_to_hard_flag;
    logic vector_read_bus_error_flag;
  } pfh_hard_t;

  // Memory management status group
  typedef struct packed {
    logic mm_lazy_fp_error_flag;
    logic mm_unstacking_error_flag;
    logic mm_stacking_error_flag;
    logic data_access_violation_flag;
    logic instr_access_violation_flag;
  } pfh_mm_t;

  // Bus fault status group
  typedef struct packed {
    logic inexact_data_bus_error_flag;
    logic exact_data_bus_error_flag;
    logic bus_lazy_fp_error_flag;
    logic prefetch_bus_error_flag;
    logic bus_unstacking_error_flag;
    logic bus_stacking_error_flag;
  } pfh_bus_t;

  // Usage fault status group
  typedef struct packed {
    logic zero_divisor_flag;
    logic unaligned_access_flag;
    logic bad_return_value_flag;
    logic bad_exec_state_flag;
    logic undefined_opcode_flag;
    logic coprocessor_access_flag;
  } pfh_usage_t;

endpackage : pfh_pkg

// ---- pfh_flag_bank.sv ----
// ============================================================
// Sticky flag bank
// ============================================================
// One flop per flag; hardware set wins over software clear.
// Assumes set and clear pulses synchronous to core_clk_in.
`timescale 1ns/1ps
`include "pfh_params.svh"

module pfh_flag_bank
  import pfh_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  // Set and clear pulses
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] clr_in,
  // Flag state
  output logic      [W-1:0] flags_out
);

  // ============================================================
  // Per-bit sticky flops
  // ============================================================
  for (genvar i = 0; i < W; i++) begin : g_bit
    // Set has priority over a same-cycle clear
    always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
        flags_out[i] <= `PFH_FLAG_RST;
      end else if (set_in[i]) begin
        flags_out[i] <= 1'h1;
      end else if (clr_in[i]) begin
        flags_out[i] <= 1'h0;
      end
    end
  end

endmodule : pfh_flag_bank

// ---- pfh_addr_capture.sv ----
// ============================================================
// Fault address capture
// ============================================================
// First faulting address is held until software clears valid.
// Assumes capture and clear are single-cycle pulses.
`timescale 1ns/1ps
`include "pfh_params.svh"

module pfh_addr_capture
  import pfh_pkg::*;
#(
  parameter int AW = `PFH_ADDR_W
) (
  // Clock and reset
  input  wire logic          core_clk_in,
  input  wire logic          rst_n_in,
  // Capture request
  input  wire logic          capture_in,
  input  wire logic [AW-1:0] addr_in,
  // Software release
  input  wire logic          clear_in,
  // Held address
  output logic      [AW-1:0] addr_out,
  output logic               valid_out
);

  // Capture when empty, or when a clear frees it this cycle
  logic take;
  assign take = capture_in && (!valid_out || clear_in);

  // Address register, frozen while valid unless a clear frees it
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      addr_out <= AW'(`PFH_ADDR_RST);
    end else if (take) begin
      addr_out <= addr_in;
    end
  end

  // Valid indication; a new capture wins over the clear
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      valid_out <= `PFH_FLAG_RST;
    end else if (take) begin
      valid_out <= 1'h1;
    end else if (clear_in) begin
      valid_out <= 1'h0;
    end
  end

endmodule : pfh_addr_capture

// ---- pfh_fault_unit.sv ----
// ============================================================
// Processor fault classification, escalation and lockup
// ============================================================
// Sorts fault events into classes, escalates, records causes
// and addresses, and drives a one-cycle request to exception
// entry. Assumes all inputs are synchronous to core_clk_in and
// that the pipeline stops issuing faults while lockup_out is high.
`timescale 1ns/1ps
`include "pfh_params.svh"

// Operation
// - Vector fetch bus error is hard fault
// - Escalation takes hard fault, sets escalated_to_hard_flag flag
// - Protection mismatch sets one memory cause flag
// - Bus errors set one bus cause flag
// - Internal errors set one usage cause flag
// - Non-executable fetch flags instruction access always
// - Configurable classes have priority and enable
// - Same-kind fault inside handler escalates
// - Equal or lower priority fault escalates
// - Fault not above running exception escalates
// - Fault with disabled handler escalates
// - Bus fault stacking into bus handler stays
// - Only reset and NMI preempt hard fault
// - Hard fault preempts all but reset, NMI
// - Capture addresses for memory and bus faults
// - Hard fault in NMI or hard handler locks
// - Lockup held until reset, NMI, debug halt
// - Lockup from NMI ignores later NMI
module pfh_fault_unit
  import pfh_pkg::*;
#(
  parameter int AW = `PFH_ADDR_W,
  parameter int PW = `PFH_PRIO_W
) (
  // Clock and reset
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_n_in,
  // Fault sources
  input  wire logic                    vector_read_err_in,
  input  wire pfh_mm_t                 mm_cause_in,
  input  wire logic                    non_executable_region_in,
  input  wire pfh_bus_t                bus_cause_in,
  input  wire pfh_usage_t              usage_cause_in,
  input  wire logic                    bus_entry_stacking_in,
  // Faulting addresses
  input  wire logic                    mm_addr_valid_in,
  input  wire logic [AW-1:0]           mm_addr_in,
  input  wire logic                    bus_addr_valid_in,
  input  wire logic [AW-1:0]           bus_addr_in,
  // Execution context
  input  wire logic                    handler_mode_in,
  input  wire logic [PW-1:0]           cur_prio_in,
  input  wire logic                    nmi_active_in,
  input  wire logic                    hard_active_in,
  // Class configuration
  input  wire logic [PW-1:0]           mm_prio_in,
  input  wire logic [PW-1:0]           bus_prio_in,
  input  wire logic [PW-1:0]           usage_prio_in,
  input  wire logic                    mm_en_in,
  input  wire logic                    bus_en_in,
  input  wire logic                    usage_en_in,
  // Software clears
  input  wire logic [`PFH_HARD_W-1:0]  hard_clr_in,
  input  wire logic [`PFH_MM_W-1:0]    mm_clr_in,
  input  wire logic [`PFH_BUS_W-1:0]   bus_clr_in,
  input  wire logic [`PFH_USAGE_W-1:0] usage_clr_in,
  input  wire logic                    mm_addr_clr_in,
  input  wire logic                    bus_addr_clr_in,
  // Lockup release events
  input  wire logic                    nmi_req_in,
  input  wire logic                    debug_halt_in,
  // Status groups
  output pfh_hard_t                    hard_fault_status_reg_out,
  output pfh_mm_t                      mem_manage_status_subreg_out,
  output pfh_bus_t                     bus_fault_status_subreg_out,
  output pfh_usage_t                   usage_fault_status_subreg_out,
  // Captured addresses
  output logic      [AW-1:0]           mem_manage_fault_address_reg_out,
  output logic                         mm_addr_valid_out,
  output logic      [AW-1:0]           bus_fault_address_reg_out,
  output logic                         bus_addr_valid_out,
  // Exception entry request
  output logic                         take_req_out,
  output pfh_class_t                   take_class_out,
  // Lockup state
  output logic                         lockup_out,
  output logic                         lockup_from_nmi_out
);

  // ============================================================
  // Event qualification
  // ============================================================
  logic       lockup_reg;
  logic       from_nmi_reg;
  logic       live;
  pfh_mm_t    mm_ev;
  pfh_bus_t   bus_ev;
  pfh_usage_t usage_ev;
  logic       mm_any;
  logic       bus_any;
  logic       usage_any;

  // No faults are accepted while locked up
  assign live = !lockup_reg;

  // Memory events; non-executable fetch flagged regardless of unit
  always_comb begin
    mm_ev = live ? mm_cause_in : '0;
    mm_ev.instr_access_violation_flag = live &&
      (mm_cause_in.instr_access_violation_flag || non_executable_region_in);
  end

  // Bus and usage events
  assign bus_ev    = live ? bus_cause_in : '0;
  assign usage_ev  = live ? usage_cause_in : '0;
  assign mm_any    = |mm_ev;
  assign bus_any   = |bus_ev;
  assign usage_any = |usage_ev;

  // ============================================================
  // Escalation decision
  // ============================================================
  logic hf_ctx;
  logic mm_esc;
  logic bus_exempt;
  logic bus_esc;
  logic usage_esc;
  logic esc_any;
  logic vec_ev;
  logic hard_ev;
  logic lock_ev;

  // Nothing configurable preempts NMI or a running hard fault
  assign hf_ctx = nmi_active_in || hard_active_in;

  // Disabled, or not above current priority inside a handler
  assign mm_esc = mm_any && (hf_ctx || !mm_en_in ||
    (handler_mode_in && (mm_prio_in >= cur_prio_in)));

  // Stacking error on bus handler entry is kept as a bus fault
  assign bus_exempt = bus_entry_stacking_in && bus_ev.bus_stacking_error_flag;
  assign bus_esc = bus_any && (hf_ctx || (!bus_exempt && (!bus_en_in ||
    (handler_mode_in && (bus_prio_in >= cur_prio_in)))));

  assign usage_esc = usage_any && (hf_ctx || !usage_en_in ||
    (handler_mode_in && (usage_prio_in >= cur_prio_in)));

  assign esc_any = mm_esc || bus_esc || usage_esc;
  assign vec_ev  = live && vector_read_err_in;
  assign hard_ev = vec_ev || esc_any;
  assign lock_ev = hard_ev && hf_ctx;

  // ============================================================
  // Status flags
  // ============================================================
  pfh_hard_t hard_set;

  // Hard group: vector read and escalated_to_hard_flag escalation
  always_comb begin
    hard_set = '0;
    hard_set.vector_read_bus_error_flag = vec_ev;
    hard_set.escalated_to_hard_flag     = esc_any;
  end

  // Hard fault status group
  pfh_flag_bank #(.W(`PFH_HARD_W)) u_hard_flags (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .set_in      (hard_set),
    .clr_in      (hard_clr_in),
    .flags_out   (hard_fault_status_reg_out)
  );

  // Memory management status group
  pfh_flag_bank #(.W(`PFH_MM_W)) u_mm_flags (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .set_in      (mm_ev),
    .clr_in      (mm_clr_in),
    .flags_out   (mem_manage_status_subreg_out)
  );

  // Bus fault status group
  pfh_flag_bank #(.W(`PFH_BUS_W)) u_bus_flags (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .set_in      (bus_ev),
    .clr_in      (bus_clr_in),
    .flags_out   (bus_fault_status_subreg_out)
  );

  // Usage fault status group
  pfh_flag_bank #(.W(`PFH_USAGE_W)) u_usage_flags (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .set_in      (usage_ev),
    .clr_in      (usage_clr_in),
    .flags_out   (usage_fault_status_subreg_out)
  );

  // ============================================================
  // Fault address capture
  // ============================================================
  // Memory management address
  pfh_addr_capture #(.AW(AW)) u_mm_addr (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .capture_in  (mm_any && mm_addr_valid_in),
    .addr_in     (mm_addr_in),
    .clear_in    (mm_addr_clr_in),
    .addr_out    (mem_manage_fault_address_reg_out),
    .valid_out   (mm_addr_valid_out)
  );

  // Bus fault address
  pfh_addr_capture #(.AW(AW)) u_bus_addr (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .capture_in  (bus_any && bus_addr_valid_in),
    .addr_in     (bus_addr_in),
    .clear_in    (bus_addr_clr_in),
    .addr_out    (bus_fault_address_reg_out),
    .valid_out   (bus_addr_valid_out)
  );

  // ============================================================
  // Exception entry request
  // ============================================================
  logic       req_next;
  pfh_class_t class_next;

  // Hard first, then memory, bus, usage
  always_comb begin
    req_next   = 1'b0;
    class_next = PFH_CLASS_HARD;
    if (hard_ev) begin
      req_next = !hf_ctx;
    end else if (mm_any) begin
      req_next   = 1'b1;
      class_next = PFH_CLASS_MM;
    end else if (bus_any) begin
      req_next   = 1'b1;
      class_next = PFH_CLASS_BUS;
    end else if (usage_any) begin
      req_next   = 1'b1;
      class_next = PFH_CLASS_USAGE;
    end
  end

  // One-cycle request pulse with its class
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      take_req_out   <= 1'b0;
      take_class_out <= PFH_CLASS_HARD;
    end else begin
      take_req_out   <= req_next;
      take_class_out <= class_next;
    end
  end

  // ============================================================
  // Lockup state
  // ============================================================
  // Enter on hard fault in NMI or hard handler, leave on release
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      lockup_reg   <= 1'b0;
      from_nmi_reg <= 1'b0;
    end else if (!lockup_reg) begin
      lockup_reg   <= lock_ev;
      from_nmi_reg <= lock_ev && nmi_active_in;
    end else if (debug_halt_in || (nmi_req_in && !from_nmi_reg)) begin
      lockup_reg   <= 1'b0;
      from_nmi_reg <= 1'b0;
    end
  end

  assign lockup_out          = lockup_reg;
  assign lockup_from_nmi_out = from_nmi_reg;

  // ============================================================
  // Checks
  // ============================================================
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  vec_read_hard_a: assert property (vec_ev && !hf_ctx |=> take_req_out &&
    take_class_out == PFH_CLASS_HARD && hard_fault_status_reg_out.vector_read_bus_error_flag)
    else $error("vector read error not taken as hard fault");

  esc_escalated_to_hard_flag_a: assert property (esc_any && !hf_ctx |=> take_class_out ==
    PFH_CLASS_HARD && hard_fault_status_reg_out.escalated_to_hard_flag)
    else $error("escalation did not force hard fault");

  mm_data_flag_a: assert property (live && mm_cause_in.data_access_violation_flag
    |=> mem_manage_status_subreg_out.data_access_violation_flag)
    else $error("data access violation flag not set");

  bus_inexact_a: assert property (live && bus_cause_in.inexact_data_bus_error_flag
    |=> bus_fault_status_subreg_out.inexact_data_bus_error_flag ##1
    (bus_fault_status_subreg_out.inexact_data_bus_error_flag || $past(bus_clr_in[5])))
    else $error("inexact bus error flag not held");

  usage_div_a: assert property (live && usage_cause_in.zero_divisor_flag
    |=> usage_fault_status_subreg_out.zero_divisor_flag)
    else $error("zero divisor flag not set");

  xn_fetch_a: assert property (live && non_executable_region_in
    |=> mem_manage_status_subreg_out.instr_access_violation_flag)
    else $error("non-executable fetch not flagged");

  disabled_esc_a: assert property (usage_any && !usage_en_in && !hf_ctx
    |=> take_req_out && take_class_out == PFH_CLASS_HARD)
    else $error("disabled usage fault not escalated");

  prio_esc_a: assert property (mm_any && handler_mode_in &&
    mm_prio_in >= cur_prio_in && !hf_ctx |=> take_class_out == PFH_CLASS_HARD)
    else $error("low priority fault not escalated");

  bus_entry_a: assert property (bus_exempt && bus_en_in && !hf_ctx && !vec_ev &&
    !mm_any && !usage_any |=> take_req_out && take_class_out == PFH_CLASS_BUS)
    else $error("bus entry stacking fault escalated");

  lock_enter_a: assert property (lock_ev |=> lockup_out && !take_req_out)
    else $error("lockup not entered");

  lock_hold_a: assert property (lockup_out && !debug_halt_in && !nmi_req_in
    |=> lockup_out)
    else $error("lockup left without release");

  nmi_no_exit_a: assert property (lockup_out && lockup_from_nmi_out &&
    !debug_halt_in |=> lockup_out)
    else $error("nmi released nmi lockup");

  addr_hold_a: assert property (mm_addr_valid_out && !mm_addr_clr_in |=>
    mem_manage_fault_address_reg_out == $past(mem_manage_fault_address_reg_out))
    else $error("held fault address changed");

  lock_cover_c:   cover property (lock_ev ##1 lockup_out ##[1:8] !lockup_out);
  esc_cover_c:    cover property (esc_any && !hf_ctx ##1 take_req_out);
  bus_entry_c:    cover property (bus_exempt && bus_en_in ##1 take_req_out);
  addr_cover_c:   cover property (mm_addr_valid_out && mm_addr_clr_in);

endmodule : pfh_fault_unit

// ---- pfh_pipe_model.sv ----
// ============================================================
// Pipeline and bus error source model
// ============================================================
// Replays a staged fault request as one-cycle fault pulses.
// Assumes the bench stages requests at core_clk_in edges.
`timescale 1ns/1ps

module pfh_pipe_model
  import pfh_pkg::*;
(
  // Clock and staged request
  input  wire logic        core_clk_in,
  input  wire logic        go_in,
  input  wire logic        vec_in,
  input  wire logic        nx_in,
  input  wire pfh_mm_t     mm_in,
  input  wire pfh_bus_t    bus_in,
  input  wire pfh_usage_t  usage_in,
  input  wire logic [31:0] addr_in,
  // Fault pulses and addresses
  output logic             vec_out,
  output logic             nx_out,
  output pfh_mm_t          mm_out,
  output pfh_bus_t         bus_out,
  output pfh_usage_t       usage_out,
  output logic             mm_av_out,
  output logic             bus_av_out,
  output logic [31:0]      mm_a_out,
  output logic [31:0]      bus_a_out
);
  // Pulses last one cycle, then drop
  always_ff @(posedge core_clk_in) begin
    vec_out    <= go_in & vec_in;
    nx_out     <= go_in & nx_in;
    mm_out     <= go_in ? mm_in : '0;
    bus_out    <= go_in ? bus_in : '0;
    usage_out  <= go_in ? usage_in : '0;
    mm_av_out  <= go_in & (|mm_in);
    bus_av_out <= go_in & (|bus_in);
  end

  // Address lines toggle when no address is offered
  always_ff @(posedge core_clk_in) begin
    mm_a_out  <= (go_in && |mm_in) ? addr_in : ~mm_a_out;
    bus_a_out <= (go_in && |bus_in) ? addr_in : ~bus_a_out;
  end
endmodule : pfh_pipe_model

// ---- tb.sv ----
// ============================================================
// Fault unit testbench
// ============================================================
// Stages faults through the pipeline model, drives context and
// clears, checks flags, addresses, requests and lockup.
`timescale 1ns/1ps

module tb
  import pfh_pkg::*;
  ;
  // Clock, reset and counters
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  int   n_fail = 0;
  int   num_checks = 0;
  // Staged fault request
  logic go = 1'b0, vec = 1'b0, nx = 1'b0;
  logic [31:0] addr = '0;
  pfh_mm_t mm_st = '0;
  pfh_bus_t bus_st = '0;
  pfh_usage_t us_st = '0;
  // Model to fault unit
  logic vector_read_err_in, non_executable_region_in, mm_addr_valid_in, bus_addr_valid_in;
  logic [31:0] mm_addr_in, bus_addr_in;
  pfh_mm_t mm_cause_in;
  pfh_bus_t bus_cause_in;
  pfh_usage_t usage_cause_in;
  // Context, configuration and clears
  logic bus_entry_stacking_in = 1'b0, handler_mode_in = 1'b0;
  logic nmi_active_in = 1'b0, hard_active_in = 1'b0;
  logic nmi_req_in = 1'b0, debug_halt_in = 1'b0;
  logic mm_en_in = 1'b1, bus_en_in = 1'b1, usage_en_in = 1'b1;
  logic mm_addr_clr_in = 1'b0, bus_addr_clr_in = 1'b0;
  logic [7:0] cur_prio_in = 8'h00, mm_prio_in = 8'h08;
  logic [7:0] bus_prio_in = 8'h08, usage_prio_in = 8'h08;
  logic [1:0] hard_clr_in = '0;
  logic [4:0] mm_clr_in = '0;
  logic [5:0] bus_clr_in = '0, usage_clr_in = '0;
  // Outputs
  pfh_hard_t hard_fault_status_reg_out;
  pfh_mm_t mem_manage_status_subreg_out;
  pfh_bus_t bus_fault_status_subreg_out;
  pfh_usage_t usage_fault_status_subreg_out;
  logic [31:0] mem_manage_fault_address_reg_out, bus_fault_address_reg_out;
  logic mm_addr_valid_out, bus_addr_valid_out, take_req_out, lockup_out, lockup_from_nmi_out;
  pfh_class_t take_class_out;

  // Clock
  always #2 core_clk_in = ~core_clk_in;

  pfh_pipe_model pfh_pipe_model_inst (
    .core_clk_in, .go_in(go), .vec_in(vec), .nx_in(nx), .mm_in(mm_st), .bus_in(bus_st),
    .usage_in(us_st), .addr_in(addr), .vec_out(vector_read_err_in),
    .nx_out(non_executable_region_in), .mm_out(mm_cause_in), .bus_out(bus_cause_in),
    .usage_out(usage_cause_in), .mm_av_out(mm_addr_valid_in), .bus_av_out(bus_addr_valid_in),
    .mm_a_out(mm_addr_in), .bus_a_out(bus_addr_in));

  pfh_fault_unit pfh_fault_unit_inst (
    .core_clk_in, .rst_n_in, .vector_read_err_in, .mm_cause_in, .non_executable_region_in,
    .bus_cause_in, .usage_cause_in, .bus_entry_stacking_in, .mm_addr_valid_in, .mm_addr_in,
    .bus_addr_valid_in, .bus_addr_in, .handler_mode_in, .cur_prio_in, .nmi_active_in,
    .hard_active_in, .mm_prio_in, .bus_prio_in, .usage_prio_in, .mm_en_in, .bus_en_in,
    .usage_en_in, .hard_clr_in, .mm_clr_in, .bus_clr_in, .usage_clr_in, .mm_addr_clr_in,
    .bus_addr_clr_in, .nmi_req_in, .debug_halt_in, .hard_fault_status_reg_out,
    .mem_manage_status_subreg_out, .bus_fault_status_subreg_out, .usage_fault_status_subreg_out,
    .mem_manage_fault_address_reg_out, .mm_addr_valid_out, .bus_fault_address_reg_out,
    .bus_addr_valid_out, .take_req_out, .take_class_out, .lockup_out, .lockup_from_nmi_out);

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  // One fault event, then request and class one cycle later
  task automatic fire(input logic v, input logic n, input pfh_mm_t m, input pfh_bus_t b,
                      input pfh_usage_t u, input logic [31:0] a, input logic er,
                      input pfh_class_t ec);
    @(posedge core_clk_in);
    go <= 1'b1;
    vec <= v;
    nx <= n;
    mm_st <= m;
    bus_st <= b;
    us_st <= u;
    addr <= a;
    @(posedge core_clk_in);
    go <= 1'b0;
    @(posedge core_clk_in);
    #1;
    chk(32'(take_req_out), 32'(er));
    if (er) chk(32'(take_class_out), 32'(ec));
    @(posedge core_clk_in);
    #1;
    chk(32'(take_req_out), 32'h0000_0000);
  endtask : fire

  // Pulse every clear, expect all flags and valids low
  task automatic clear_all;
    @(posedge core_clk_in);
    {hard_clr_in, mm_clr_in, bus_clr_in, usage_clr_in} <= '1;
    {mm_addr_clr_in, bus_addr_clr_in} <= 2'h3;
    @(posedge core_clk_in);
    {hard_clr_in, mm_clr_in, bus_clr_in, usage_clr_in} <= '0;
    {mm_addr_clr_in, bus_addr_clr_in} <= 2'h0;
    #1;
    chk(32'({hard_fault_status_reg_out, mem_manage_status_subreg_out,
             bus_fault_status_subreg_out, usage_fault_status_subreg_out,
             mm_addr_valid_out, bus_addr_valid_out}), 32'h0000_0000);
  endtask : clear_all

  // Lockup release attempt by NMI or debugger halt
  task automatic wake(input logic dbg, input logic exp);
    @(posedge core_clk_in);
    nmi_req_in <= ~dbg;
    debug_halt_in <= dbg;
    @(posedge core_clk_in);
    nmi_req_in <= 1'b0;
    debug_halt_in <= 1'b0;
    #1;
    chk(32'(lockup_out), 32'(exp));
  endtask : wake

  // Hang guard
  initial begin
    repeat (5000) @(posedge core_clk_in);
    n_fail++;
    complete_run;
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    #1;
    chk(32'({take_req_out, lockup_out, mm_addr_valid_out}), 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      fire(0, 0, '0, '0, 6'h01 << i, '0, 1, PFH_CLASS_USAGE);
      chk(32'(usage_fault_status_subreg_out), 32'(6'h01 << i));
      clear_all;
    end
    $display("test usage causes done");
    for (int i = 0; i < 5; i++) begin
      fire(0, 0, 5'h01 << i, '0, '0, 32'h2000_0100 + i, 1, PFH_CLASS_MM);
      chk(32'(mem_manage_status_subreg_out), 32'(5'h01 << i));
      chk(mem_manage_fault_address_reg_out, 32'h2000_0100 + i);
      clear_all;
    end
    for (int i = 0; i < 6; i++) begin
      fire(0, 0, '0, 6'h01 << i, '0, 32'h4000_0200 + i, 1, PFH_CLASS_BUS);
      chk(32'(bus_fault_status_subreg_out), 32'(6'h01 << i));
      chk(bus_fault_address_reg_out, 32'h4000_0200 + i);
      clear_all;
    end
    $display("test memory and bus causes done");
    fire(0, 0, '0, 6'h10, '0, 32'h4000_0A00, 1, PFH_CLASS_BUS);
    fire(0, 0, '0, 6'h20, '0, 32'h4000_0B00, 1, PFH_CLASS_BUS);
    chk(32'(bus_fault_status_subreg_out), 32'h0000_0030);
    chk(bus_fault_address_reg_out, 32'h4000_0A00);
    clear_all;
    fire(0, 1, '0, '0, '0, '0, 1, PFH_CLASS_MM);
    chk(32'(mem_manage_status_subreg_out), 32'h0000_0001);
    clear_all;
    handler_mode_in <= 1'b1;
    fire(1, 0, '0, '0, '0, '0, 1, PFH_CLASS_HARD);
    chk(32'(hard_fault_status_reg_out), 32'h0000_0001);
    clear_all;
    handler_mode_in <= 1'b0;
    usage_en_in <= 1'b0;
    fire(0, 0, '0, '0, 6'h20, '0, 1, PFH_CLASS_HARD);
    chk(32'(hard_fault_status_reg_out), 32'h0000_0002);
    chk(32'(usage_fault_status_subreg_out), 32'h0000_0020);
    clear_all;
    usage_en_in <= 1'b1;
    bus_en_in <= 1'b0;
    bus_entry_stacking_in <= 1'b1;
    fire(0, 0, '0, 6'h01, '0, 32'h2000_0400, 1, PFH_CLASS_BUS);
    clear_all;
    bus_entry_stacking_in <= 1'b0;
    fire(0, 0, '0, 6'h01, '0, 32'h2000_0400, 1, PFH_CLASS_HARD);
    clear_all;
    bus_en_in <= 1'b1;
    $display("test escalation by enable done");
    handler_mode_in <= 1'b1;
    cur_prio_in <= 8'h04;
    for (int p = 3; p < 6; p++) begin
      usage_prio_in <= 8'(p);
      fire(0, 0, '0, '0, 6'h01, '0, 1,
           p > 3 ? PFH_CLASS_HARD : PFH_CLASS_USAGE);
      chk(32'(hard_fault_status_reg_out), p > 3 ? 32'h0000_0002 : 32'h0000_0000);
      clear_all;
    end
    fire(0, 0, 5'h02, '0, '0, 32'h2000_0500, 1, PFH_CLASS_HARD);
    chk(32'({hard_fault_status_reg_out, mem_manage_status_subreg_out}), 32'h0000_0042);
    chk(mem_manage_fault_address_reg_out, 32'h2000_0500);
    clear_all;
    $display("test escalation by priority done");
    hard_active_in <= 1'b1;
    fire(1, 0, '0, '0, '0, '0, 0, PFH_CLASS_HARD);
    chk(32'({lockup_out, lockup_from_nmi_out}), 32'h0000_0002);
    hard_active_in <= 1'b0;
    fire(0, 0, '0, '0, 6'h02, '0, 0, PFH_CLASS_HARD);
    chk(32'({lockup_out, usage_fault_status_subreg_out}), 32'h0000_0040);
    wake(1'b0, 1'b0);
    nmi_active_in <= 1'b1;
    fire(1, 0, '0, '0, '0, '0, 0, PFH_CLASS_HARD);
    chk(32'({lockup_out, lockup_from_nmi_out}), 32'h0000_0003);
    nmi_active_in <= 1'b0;
    wake(1'b0, 1'b1);
    wake(1'b1, 1'b0);
    $display("test lockup done");
    complete_run;
  end
endmodule : tb
